// ---- rtl/cgc_pkg.sv ----
// Purpose: Shared constants and types of the counter gate and compare block
// Assumes: One clock domain, Wishbone register map at word-aligned byte offsets
// Notes: All offsets, bit positions and reset values live here
package cgc_pkg;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned IRQ_W = 3;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CFG = 8'h04;
  localparam logic [7:0] ADR_CMP = 8'h08;
  localparam logic [7:0] ADR_LOAD = 8'h0c;
  localparam logic [7:0] ADR_COUNT = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h1c;
  localparam logic [7:0] ADR_IRQ_EN = 8'h20;
  // Control word bits
  localparam int unsigned CTRL_OPEN = 0;
  localparam int unsigned CTRL_CLOSE = 1;
  localparam int unsigned CTRL_CMPCTL = 2;
  localparam int unsigned CTRL_RESSTS = 3;
  // Configuration fields
  localparam int unsigned CFG_ONCE = 0;
  localparam int unsigned CFG_INTR = 1;
  localparam int unsigned CFG_MODE = 2;
  localparam int unsigned CFG_ACT = 4;
  localparam int unsigned CFG_HYST = 8;
  // Status bits
  localparam int unsigned ST_SWGATE = 0;
  localparam int unsigned ST_IGATE = 1;
  localparam int unsigned ST_CMP = 2;
  localparam int unsigned ST_OVF = 3;
  localparam int unsigned ST_UNF = 4;
  localparam int unsigned ST_CMPCTL = 5;
  // Interrupt bits
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_UNF = 1;
  localparam int unsigned IRQ_CMP = 2;
  // Limits and reset values
  localparam logic [31:0] CNT_MAX = 32'h7fffffff;
  localparam logic [31:0] CNT_MIN = 32'h80000000;
  localparam logic [7:0] HYST_MIN = 8'h02;
  localparam logic [31:0] REG_RST = 32'h00000000;
  typedef enum logic [1:0] {
    CGC_CMP_NONE = 2'b00,
    CGC_CMP_GE = 2'b01,
    CGC_CMP_LT = 2'b10,
    CGC_CMP_EQ = 2'b11
  } cgc_cmp_mode_t;
  typedef enum logic [1:0] {
    CGC_ACT_NONE = 2'b00,
    CGC_ACT_ON = 2'b01,
    CGC_ACT_OFF = 2'b10,
    CGC_ACT_RSV = 2'b11
  } cgc_out_act_t;
  typedef enum logic {
    CGC_HY_IDLE = 1'b0,
    CGC_HY_HOLD = 1'b1
  } cgc_hyst_st_t;
endpackage

// ---- rtl/cgc_cnt_if.sv ----
// Purpose: Carries counter state from the counter core to the top
// Assumes: Single clock domain
// Notes: Event signals are one-cycle pulses
`timescale 1ns/1ps
interface cgc_cnt_if;
  logic [31:0] count;
  logic igate;
  logic software_gate;
  logic ovf_evt;
  logic unf_evt;
  modport cnt (output count, igate, software_gate, ovf_evt, unf_evt);
  modport mon (input count, igate, software_gate, ovf_evt, unf_evt);
endinterface

// ---- rtl/cgc_edge.sv ----
// Purpose: Rising-edge detection on each newly received control word
// Assumes: load_i marks the cycle a new word is received
// Notes: Rises are combinational pulses in the receive cycle
`timescale 1ns/1ps
module cgc_edge
  import cgc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Word in
  input wire logic load_i,
  input wire logic [CTRL_W-1:0] word_i,
  // Stored word and edges
  output logic [CTRL_W-1:0] word_o,
  output logic [CTRL_W-1:0] rise_o
);
  logic [CTRL_W-1:0] prev_d;
  logic [CTRL_W-1:0] prev_q;

  always_comb
  begin
    prev_d = load_i ? word_i : prev_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= REG_RST[CTRL_W-1:0];
    else
      prev_q <= prev_d;
  end

  genvar g;
  generate
    for (g = 0; g < CTRL_W; g++)
    begin : g_bit
      assign rise_o[g] = load_i & word_i[g] & ~prev_q[g];
    end
  endgenerate

  assign word_o = prev_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_edge_only_rise: assert property (rise_o[CTRL_OPEN] |=> prev_q[CTRL_OPEN]
    ##1 (!rise_o[CTRL_OPEN] || !$past(prev_q[CTRL_OPEN], 1) || $past(load_i, 1)))
    else $error("open edge seen without a 0 to 1 change");
endmodule

// ---- rtl/cgc_counter.sv ----
// Purpose: Software gate, internal gate and 32-bit up/down count core
// Assumes: Count pulses are one cycle wide and synchronous
// Notes: Up and down in the same cycle cancel and do not count
`timescale 1ns/1ps
module cgc_counter
  import cgc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Gate requests and mode
  input wire logic open_evt_i,
  input wire logic close_evt_i,
  input wire logic once_i,
  input wire logic interrupting_i,
  input wire logic [CNT_W-1:0] load_val_i,
  // Count pulses
  input wire logic cnt_up_i,
  input wire logic cnt_dn_i,
  // Counter state out
  cgc_cnt_if.cnt bus
);
  logic sw_d, sw_q, ig_d, ig_q, ovf_d, ovf_q, unf_d, unf_q;
  logic [CNT_W-1:0] cnt_d, cnt_q;

  always_comb
  begin
    sw_d = sw_q;
    ig_d = ig_q;
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    unf_d = 1'b0;
    if (open_evt_i)
    begin
      sw_d = 1'b1;
      ig_d = 1'b1;
      if (!ig_q && !interrupting_i)
        cnt_d = load_val_i;
    end
    if (close_evt_i)
    begin
      sw_d = 1'b0;
      ig_d = 1'b0;
    end
    else if (ig_q && (cnt_up_i ^ cnt_dn_i))
    begin
      if (cnt_up_i)
      begin
        cnt_d = cnt_q + 32'h00000001;
        ovf_d = (cnt_q == CNT_MAX);
      end
      else
      begin
        cnt_d = cnt_q - 32'h00000001;
        unf_d = (cnt_q == CNT_MIN);
      end
      if (once_i && (ovf_d || unf_d))
        ig_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_q <= 1'b0;
      ig_q <= 1'b0;
      cnt_q <= REG_RST;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end
    else
    begin
      sw_q <= sw_d;
      ig_q <= ig_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
    end
  end

  assign bus.count = cnt_q;
  assign bus.igate = ig_q;
  assign bus.software_gate = sw_q;
  assign bus.ovf_evt = ovf_q;
  assign bus.unf_evt = unf_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_reopen;
    !ig_q && open_evt_i && interrupting_i && !close_evt_i;
  endsequence

  chk_open_gate: assert property (open_evt_i && !close_evt_i |=> ig_q && sw_q)
    else $error("gate not open after open request");
  chk_close_gate: assert property (close_evt_i |=> !ig_q && !sw_q)
    else $error("gate not closed after close request");
  chk_once_reopen: assert property (!ig_q && !open_evt_i |=> !ig_q)
    else $error("gate reopened without open request");
  chk_gate_follow: assert property (!sw_q |-> !ig_q)
    else $error("internal gate open while software gate closed");
  chk_no_count: assert property (!ig_q && !open_evt_i |=> $stable(cnt_q))
    else $error("counter moved with gate closed");
  chk_resume_value: assert property (s_reopen |=> cnt_q == $past(cnt_q))
    else $error("counter reloaded on interrupting reopen");
  chk_once_close: assert property (ig_q && once_i && cnt_up_i && !cnt_dn_i &&
    !close_evt_i && cnt_q == CNT_MAX |=> !ig_q && ovf_q ##1 !ovf_q)
    else $error("count once overflow did not close gate");
endmodule

// ---- rtl/cgc_top.sv ----
// Purpose: Counter channel with gate control, comparison and hysteresis
// Assumes: Classic Wishbone slave, 32-bit data, one clock
// Notes: Control word edges act on the cycle a write to it is taken
`timescale 1ns/1ps
module cgc_top
  import cgc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Count pulses
  input wire logic cnt_up_i,
  input wire logic cnt_dn_i,
  // Channel outputs
  output logic dout_o,
  output logic irq_o
);
  cgc_cnt_if cnt_bus();

  logic req, wr;
  logic [7:0] adr;
  logic ack_d, ack_q;
  logic [31:0] rdat_d, rdat_q;
  logic [31:0] cfg_d, cfg_q;
  logic [31:0] cmpv_d, cmpv_q;
  logic [31:0] load_d, load_q;
  logic [IRQ_W-1:0] ien_d, ien_q;
  logic [IRQ_W-1:0] ist_d, ist_q;
  logic [IRQ_W-1:0] iclr;
  logic [IRQ_W-1:0] ievt;
  logic ovf_d, ovf_q, unf_d, unf_q;
  logic dout_d, dout_q, irq_d, irq_q;
  logic [31:0] ctrl_full;
  logic [CTRL_W-1:0] ctrl_word;
  logic [CTRL_W-1:0] ctrl_rise;
  logic wr_ctrl;

  // Byte lanes that are not selected keep their old contents
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  // Bus slave: ack one cycle after the request, then released
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wr_ctrl = wr & (adr == ADR_CTRL);
  assign ctrl_full = lane_merge({28'h0000000, ctrl_word}, wb_dat_i, wb_sel_i);

  cgc_edge u_edge (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .load_i (wr_ctrl),
    .word_i (ctrl_full[CTRL_W-1:0]),
    .word_o (ctrl_word),
    .rise_o (ctrl_rise)
  );

  cgc_counter u_counter (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .open_evt_i (ctrl_rise[CTRL_OPEN]),
    .close_evt_i (ctrl_rise[CTRL_CLOSE]),
    .once_i (cfg_q[CFG_ONCE]),
    .interrupting_i (cfg_q[CFG_INTR]),
    .load_val_i (load_q),
    .cnt_up_i (cnt_up_i),
    .cnt_dn_i (cnt_dn_i),
    .bus (cnt_bus.cnt)
  );

  // Comparison unit
  cgc_cmp_mode_t mode;
  cgc_out_act_t act;
  cgc_hyst_st_t hst_d, hst_q;
  logic cmp_ctl;
  logic raw, raw_q;
  logic flag_d, flag_q;
  logic [31:0] cen_d, cen_q;
  logic [7:0] hy_d, hy_q;
  logic signed [32:0] diff;
  logic [32:0] mag;
  logic in_range;
  logic cmp_rise;

  assign mode = cgc_cmp_mode_t'(cfg_q[CFG_MODE +: 2]);
  assign act = cgc_out_act_t'(cfg_q[CFG_ACT +: 2]);
  assign cmp_ctl = ctrl_word[CTRL_CMPCTL];

  always_comb
  begin
    case (mode)
      CGC_CMP_GE: raw = $signed(cnt_bus.count) >= $signed(cmpv_q);
      CGC_CMP_LT: raw = $signed(cnt_bus.count) < $signed(cmpv_q);
      CGC_CMP_EQ: raw = cnt_bus.count == cmpv_q;
      default: raw = flag_q;
    endcase
  end

  // Distance from the point where the hold began
  always_comb
  begin
    diff = $signed({cnt_bus.count[31], cnt_bus.count}) - $signed({cen_q[31], cen_q});
    mag = diff[32] ? 33'(-diff) : 33'(diff);
    in_range = mag < {25'h0000000, hy_q};
  end

  // Hold starts on reaching the condition; the width is taken at that moment
  always_comb
  begin
    flag_d = flag_q;
    hst_d = hst_q;
    cen_d = cen_q;
    hy_d = hy_q;
    if (cmp_ctl && mode != CGC_CMP_NONE)
    begin
      case (hst_q)
        CGC_HY_IDLE:
        begin
          flag_d = raw;
          if (raw && !raw_q && hy_q_ok(cfg_q[CFG_HYST +: 8]))
          begin
            hst_d = CGC_HY_HOLD;
            cen_d = cnt_bus.count;
            hy_d = cfg_q[CFG_HYST +: 8];
          end
        end
        CGC_HY_HOLD:
        begin
          if (!in_range)
          begin
            hst_d = CGC_HY_IDLE;
            flag_d = raw;
          end
        end
        default: hst_d = CGC_HY_IDLE;
      endcase
    end
  end

  function automatic logic hy_q_ok(input logic [7:0] w);
    return w >= HYST_MIN;
  endfunction

  assign cmp_rise = flag_d & ~flag_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_q <= 1'b0;
      raw_q <= 1'b0;
      hst_q <= CGC_HY_IDLE;
      cen_q <= REG_RST;
      hy_q <= REG_RST[7:0];
    end
    else
    begin
      flag_q <= flag_d;
      raw_q <= raw;
      hst_q <= hst_d;
      cen_q <= cen_d;
      hy_q <= hy_d;
    end
  end

  // Registers, status flags and interrupt
  always_comb
  begin
    cfg_d = cfg_q;
    cmpv_d = cmpv_q;
    load_d = load_q;
    ien_d = ien_q;
    iclr = '0;
    if (wr)
    begin
      case (adr)
        ADR_CFG: cfg_d = lane_merge(cfg_q, wb_dat_i, wb_sel_i);
        ADR_CMP: cmpv_d = lane_merge(cmpv_q, wb_dat_i, wb_sel_i);
        ADR_LOAD: load_d = lane_merge(load_q, wb_dat_i, wb_sel_i);
        ADR_IRQ_EN: ien_d = wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0] : ien_q;
        ADR_IRQ_CLR: iclr = wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0] : '0;
        default: ;
      endcase
    end
    ievt[IRQ_OVF] = cnt_bus.ovf_evt;
    ievt[IRQ_UNF] = cnt_bus.unf_evt;
    ievt[IRQ_CMP] = cmp_rise;
    // A new event wins over a clear in the same cycle
    ist_d = (ist_q & ~iclr) | ievt;
    ovf_d = (ovf_q & ~ctrl_rise[CTRL_RESSTS]) | cnt_bus.ovf_evt;
    unf_d = (unf_q & ~ctrl_rise[CTRL_RESSTS]) | cnt_bus.unf_evt;
    irq_d = |(ist_d & ien_d);
    case (act)
      CGC_ACT_ON: dout_d = flag_d;
      CGC_ACT_OFF: dout_d = ~flag_d;
      default: dout_d = 1'b0;
    endcase
  end

  // Read data is captured with the ack; unmapped offsets read zero
  always_comb
  begin
    ack_d = req;
    rdat_d = REG_RST;
    if (req && !wb_we_i)
    begin
      case (adr)
        ADR_CTRL: rdat_d = {28'h0000000, ctrl_word};
        ADR_CFG: rdat_d = cfg_q;
        ADR_CMP: rdat_d = cmpv_q;
        ADR_LOAD: rdat_d = load_q;
        ADR_COUNT: rdat_d = cnt_bus.count;
        ADR_STATUS: rdat_d = {26'h0000000, cmp_ctl, unf_q, ovf_q, flag_q,
                              cnt_bus.igate, cnt_bus.software_gate};
        ADR_IRQ_STAT: rdat_d = {29'h00000000, ist_q};
        ADR_IRQ_EN: rdat_d = {29'h00000000, ien_q};
        default: rdat_d = REG_RST;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= REG_RST;
      cfg_q <= REG_RST;
      cmpv_q <= REG_RST;
      load_q <= REG_RST;
      ien_q <= '0;
      ist_q <= '0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      irq_q <= 1'b0;
      dout_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      cfg_q <= cfg_d;
      cmpv_q <= cmpv_d;
      load_q <= load_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      irq_q <= irq_d;
      dout_q <= dout_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign dout_o = dout_q;
  assign irq_o = irq_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_idle_ctl;
    cmp_ctl && hst_q == CGC_HY_IDLE;
  endsequence

  chk_flag_frozen: assert property (!cmp_ctl |=> $stable(flag_q))
    else $error("compare flag moved without control bit");
  chk_none_mode: assert property (mode == CGC_CMP_NONE |=> $stable(flag_q))
    else $error("compare flag moved in mode none");
  chk_ge_flag: assert property (s_idle_ctl ##0 mode == CGC_CMP_GE |=>
    flag_q == ($signed($past(cnt_bus.count)) >= $signed($past(cmpv_q))))
    else $error("greater-or-equal flag wrong");
  chk_lt_flag: assert property (s_idle_ctl ##0 mode == CGC_CMP_LT |=>
    flag_q == ($signed($past(cnt_bus.count)) < $signed($past(cmpv_q))))
    else $error("less-than flag wrong");
  chk_eq_flag: assert property (s_idle_ctl ##0 mode == CGC_CMP_EQ |=>
    flag_q == ($past(cnt_bus.count) == $past(cmpv_q)))
    else $error("equality flag wrong");
  chk_dout_follow: assert property (act == CGC_ACT_ON ##1 act == CGC_ACT_ON |->
    dout_q == flag_q)
    else $error("digital output does not follow compare flag");
  chk_irq_level: assert property (##1 irq_q == |($past(ist_d) & $past(ien_d)))
    else $error("interrupt level wrong");
  chk_hyst_hold: assert property (hst_q == CGC_HY_HOLD && in_range |=>
    $stable(flag_q))
    else $error("compare flag toggled inside hysteresis");
  chk_hyst_off: assert property (hst_q == CGC_HY_IDLE &&
    cfg_q[CFG_HYST +: 8] < HYST_MIN |=> hst_q == CGC_HY_IDLE)
    else $error("hysteresis active at width 0 or 1");
  chk_ovf_sticky: assert property (cnt_bus.ovf_evt |=> ovf_q [*2])
    else $error("overflow flag not sticky");
  chk_unf_sticky: assert property (cnt_bus.unf_evt |=> unf_q [*2])
    else $error("underflow flag not sticky");
  chk_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
endmodule

// ---- bench/cgc_host_model.sv ----
// Purpose: Host side bus coupler model, a classic Wishbone master
// Assumes: One clock, slave answers with a registered one-cycle ack
// Notes: Released address and data lines show inverted values, never the last ones
`timescale 1ns/1ps
module cgc_host_model
(
  // Clock
  input wire logic clk_i,
  // Wishbone master side
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'hff;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h5a5a5a5a;
  end

  // One classic cycle; the request holds until ack is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    do
      @(posedge clk_i);
    while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~a;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~d;
  endtask
endmodule

// ---- bench/cgc_top_bench.sv ----
// Purpose: Self-checking bench of the counter gate and compare channel
// Assumes: Host model drives the register bus, bench drives count pulses
// Notes: Count positions are set by reloading through an aborting gate reopen
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module cgc_top_bench
  import cgc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cnt_up_i = 1'b0;
  logic cnt_dn_i = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, dout_o, irq_o;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  int miscompares = 0;
  int n_compared = 0;

  always #10 clk_i = ~clk_i;

  cgc_top u_cgc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .cnt_up_i(cnt_up_i), .cnt_dn_i(cnt_dn_i),
    .dout_o(dout_o), .irq_o(irq_o));

  cgc_host_model u_cgc_host_model (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
    .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
    .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat));

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_cgc_host_model.xfer(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    u_cgc_host_model.xfer(1'b0, a, 32'h0, 4'hf, q);
    `CHK(q & m, e)
  endtask

  task automatic pulse(input logic up, input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      cnt_up_i <= up;
      cnt_dn_i <= !up;
      @(posedge clk_i);
      cnt_up_i <= 1'b0;
      cnt_dn_i <= 1'b0;
    end
  endtask

  // Close, drop the open bit, then raise it: a fresh edge reloads in aborting mode
  task automatic ld(input logic [31:0] v, input logic [31:0] c);
    wr(ADR_LOAD, v);
    wr(ADR_CTRL, c | 32'h2);
    wr(ADR_CTRL, c);
    wr(ADR_CTRL, c | 32'h1);
  endtask

  task automatic t_reset;
    logic [7:0] adrs[9] = '{ADR_CTRL, ADR_CFG, ADR_CMP, ADR_LOAD, ADR_COUNT, ADR_STATUS,
                            ADR_IRQ_STAT, ADR_IRQ_CLR, ADR_IRQ_EN};
    foreach (adrs[i])
      rd_chk(adrs[i], 32'hffffffff, REG_RST);
    `CHK({dout_o, irq_o}, 2'b00)
    wr(8'h24, 32'hffffffff);
    rd_chk(8'h24, 32'hffffffff, 32'h0);
    wr(ADR_CMP, 32'h0000000a);
    rd_chk(ADR_CMP, 32'hffffffff, 32'h0000000a);
    // Only byte lane 1 is selected, the other lanes keep their contents
    u_cgc_host_model.xfer(1'b1, ADR_CMP, 32'h12345678, 4'h2, q);
    rd_chk(ADR_CMP, 32'hffffffff, 32'h0000560a);
    wr(ADR_CMP, 32'h0000000a);
  endtask

  task automatic t_gate;
    wr(ADR_CFG, 32'h0);
    ld(32'h5, 32'h0);
    rd_chk(ADR_STATUS, 32'h3, 32'h3);
    pulse(1'b1, 3);
    rd_chk(ADR_COUNT, 32'hffffffff, 32'h8);
    wr(ADR_CTRL, 32'h3);
    rd_chk(ADR_STATUS, 32'h3, 32'h0);
    pulse(1'b1, 2);
    rd_chk(ADR_COUNT, 32'hffffffff, 32'h8);
    wr(ADR_CTRL, 32'h1);
    rd_chk(ADR_STATUS, 32'h3, 32'h0);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h1);
    rd_chk(ADR_COUNT, 32'hffffffff, 32'h5);
    wr(ADR_CFG, 32'h2);
    pulse(1'b1, 2);
    ld(32'h5, 32'h0);
    rd_chk(ADR_COUNT, 32'hffffffff, 32'h7);
  endtask

  task automatic t_once;
    wr(ADR_CFG, 32'h1);
    ld(32'h7ffffffe, 32'h0);
    pulse(1'b1, 3);
    rd_chk(ADR_COUNT, 32'hffffffff, CNT_MIN);
    rd_chk(ADR_STATUS, 32'h0a, 32'h08);
    wr(ADR_CTRL, 32'h1);
    rd_chk(ADR_STATUS, 32'h2, 32'h0);
    rd_chk(ADR_IRQ_STAT, 32'h1, 32'h1);
    `CHK(irq_o, 1'b0)
    wr(ADR_IRQ_EN, 32'h1);
    @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(ADR_IRQ_CLR, 32'h1);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(ADR_CTRL, 32'h8);
    rd_chk(ADR_STATUS, 32'h8, 32'h0);
    wr(ADR_CTRL, 32'h9);
    rd_chk(ADR_STATUS, 32'h2, 32'h2);
    rd_chk(ADR_COUNT, 32'hffffffff, 32'h7ffffffe);
    ld(CNT_MIN, 32'h0);
    pulse(1'b0, 2);
    rd_chk(ADR_COUNT, 32'hffffffff, CNT_MAX);
    rd_chk(ADR_STATUS, 32'h12, 32'h10);
    rd_chk(ADR_IRQ_STAT, 32'h2, 32'h2);
  endtask

  task automatic t_cmp;
    logic e;
    for (int m = 1; m < 4; m++)
    begin
      wr(ADR_CFG, 32'(m << 2) | 32'h10);
      ld(32'h9, 32'h4);
      for (int k = 0; k < 3; k++)
      begin
        e = (m == 1) ? (k >= 1) : (m == 2) ? (k < 1) : (k == 1);
        rd_chk(ADR_STATUS, 32'h4, {29'h0, e, 2'h0});
        `CHK(dout_o, e)
        if (k < 2)
          pulse(1'b1, 1);
      end
    end
    rd_chk(ADR_IRQ_STAT, 32'h4, 32'h4);
    wr(ADR_CFG, 32'h14);
    wr(ADR_CTRL, 32'h1);
    pulse(1'b0, 3);
    rd_chk(ADR_STATUS, 32'h4, 32'h4);
    wr(ADR_CTRL, 32'h5);
    rd_chk(ADR_STATUS, 32'h4, 32'h0);
    wr(ADR_CFG, 32'h10);
    pulse(1'b1, 3);
    rd_chk(ADR_STATUS, 32'h4, 32'h0);
    wr(ADR_CFG, 32'h24);
    rd_chk(ADR_STATUS, 32'h4, 32'h4);
    `CHK(dout_o, 1'b0)
  endtask

  task automatic t_hyst;
    wr(ADR_CFG, 32'h0314);
    ld(32'h9, 32'h4);
    pulse(1'b1, 1);
    rd_chk(ADR_STATUS, 32'h4, 32'h4);
    pulse(1'b0, 2);
    rd_chk(ADR_STATUS, 32'h4, 32'h4);
    pulse(1'b0, 1);
    rd_chk(ADR_STATUS, 32'h4, 32'h0);
    wr(ADR_CFG, 32'h0114);
    ld(32'h9, 32'h4);
    pulse(1'b1, 1);
    rd_chk(ADR_STATUS, 32'h4, 32'h4);
    pulse(1'b0, 1);
    rd_chk(ADR_STATUS, 32'h4, 32'h0);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gate();
    t_once();
    t_cmp();
    t_hyst();
    close_out();
  end

  // Whole run needs a few hundred cycles; far beyond that means a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
endmodule
